//--- hdl/cpu_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_dp_defs.svh"

module cpu_datapath #(
	parameter logic [15:0] SRAM_END = `SRAM_LAST,
	parameter int          SP_W     = 8
) (
	input  wire logic             aclk, // RQ21
	input  wire logic             aresetn,
	input  wire logic             cmd_valid,
	input  wire cpu_dp_pkg::cmd_t cmd,
	output var  logic             cmd_ready,
	input  wire logic             irq_req,
	output var  logic             irq_taken,
	output var  logic [7:0]       cpu_flags,
	output var  logic [SP_W-1:0]  stack_ptr,
	output var  logic [7:0]       alu_result,
	output var  logic [15:0]      mem_addr,
	output var  logic [7:0]       mem_wdata,
	output var  logic             mem_we,
	output var  logic             mem_re,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output var  logic             s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output var  logic             s_axi_wready,
	output var  logic [1:0]       s_axi_bresp,
	output var  logic             s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output var  logic             s_axi_arready,
	output var  logic [31:0]      s_axi_rdata,
	output var  logic [1:0]       s_axi_rresp,
	output var  logic             s_axi_rvalid,
	input  wire logic             s_axi_rready
);
	logic [7:0]         rf [0:31];
	cpu_dp_pkg::state_t state;
	logic [1:0]         wait_cnt;
	logic               accept;
	logic               take_irq;
	logic               bus_wr;
	logic               bus_rd;
	logic [5:0]         widx;
	logic [5:0]         ridx;
	cpu_dp_pkg::alu_out_t alu_o;
	logic [7:0]         opa;
	logic [7:0]         opb;
	logic [4:0]         pidx;
	logic [15:0]        ptr;
	logic [15:0]        w16;
	logic [15:0]        sum16;
	logic               wr8;
	logic               wr16;
	logic               wr_ptr;
	logic [15:0]        next_ptr;
	logic [7:0]         next_flags;
	logic [SP_W-1:0]    next_sp;
	logic [15:0]        next_addr;
	logic               next_we;
	logic               next_re;
	cpu_dp_pkg::state_t next_state;

	function automatic logic is_mapped(input logic [5:0] idx);
		return idx < `NUM_WREGS || idx == `IDX_SP_LOW ||
			idx == `IDX_SP_HIGH || idx == `IDX_FLAGS;
	endfunction : is_mapped

	// 8-bit arithmetic and logic with flag update; I and T pass through
	function automatic cpu_dp_pkg::alu_out_t alu8(
		input cpu_dp_pkg::op_t op,
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] f
	);
		logic [8:0] r;
		cpu_dp_pkg::alu_out_t o;
		r = 9'h000;
		o.flags = f;
		unique case (op)
			cpu_dp_pkg::OP_ADD, cpu_dp_pkg::OP_ADC:
			begin
				r = {1'b0, a} + {1'b0, b} +
					{8'h00, op == cpu_dp_pkg::OP_ADC && f[`FLAG_C]};
				o.flags[`FLAG_H] = a[3] & b[3] | b[3] & ~r[3] | ~r[3] & a[3]; // RQ8
				o.flags[`FLAG_V] = a[7] & b[7] & ~r[7] | ~a[7] & ~b[7] & r[7]; // RQ10
				o.flags[`FLAG_C] = r[8]; // RQ11
			end
			cpu_dp_pkg::OP_SUB, cpu_dp_pkg::OP_SBC, cpu_dp_pkg::OP_SUBI:
			begin
				r = {1'b0, a} - {1'b0, b} -
					{8'h00, op == cpu_dp_pkg::OP_SBC && f[`FLAG_C]};
				o.flags[`FLAG_H] = ~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3]; // RQ8
				o.flags[`FLAG_V] = a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7]; // RQ10
				o.flags[`FLAG_C] = r[8]; // RQ11
			end
			cpu_dp_pkg::OP_AND, cpu_dp_pkg::OP_ANDI:
			begin
				r = {1'b0, a & b};
				o.flags[`FLAG_V] = 1'b0;
			end
			cpu_dp_pkg::OP_OR, cpu_dp_pkg::OP_ORI:
			begin
				r = {1'b0, a | b};
				o.flags[`FLAG_V] = 1'b0;
			end
			cpu_dp_pkg::OP_EOR:
			begin
				r = {1'b0, a ^ b};
				o.flags[`FLAG_V] = 1'b0;
			end
			default:
				r = {1'b0, b};
		endcase
		o.res = r[7:0];
		case (op)
			cpu_dp_pkg::OP_ADD, cpu_dp_pkg::OP_ADC, cpu_dp_pkg::OP_SUB,
			cpu_dp_pkg::OP_SBC, cpu_dp_pkg::OP_SUBI, cpu_dp_pkg::OP_AND,
			cpu_dp_pkg::OP_ANDI, cpu_dp_pkg::OP_OR, cpu_dp_pkg::OP_ORI,
			cpu_dp_pkg::OP_EOR:
			begin
				o.flags[`FLAG_N] = r[7]; // RQ10
				// carry-chained subtract only keeps zero if it was already zero
				o.flags[`FLAG_Z] = (r[7:0] == 8'h00) &
					(op != cpu_dp_pkg::OP_SBC || f[`FLAG_Z]); // RQ11
				o.flags[`FLAG_S] = r[7] ^ o.flags[`FLAG_V]; // RQ9
			end
			default:
				o.flags = f;
		endcase
		return o;
	endfunction : alu8

	assign accept   = cmd_valid && cmd_ready;
	// interrupt only when the pipe is idle and the global enable is set
	assign take_irq = state == cpu_dp_pkg::ST_RUN && !cmd_valid &&
		irq_req && cpu_flags[`FLAG_I]; // RQ5
	assign bus_wr   = s_axi_awready && s_axi_awvalid;
	assign bus_rd   = s_axi_arready && s_axi_arvalid;
	assign widx     = s_axi_awaddr[7:2];
	assign ridx     = s_axi_araddr[7:2];

	// operands are read combinationally so execute and write back share a cycle
	always_comb
	begin
		opa   = rf[cmd.dst]; // RQ1 RQ22
		opb   = (cmd.op == cpu_dp_pkg::OP_SUBI || cmd.op == cpu_dp_pkg::OP_ANDI ||
			cmd.op == cpu_dp_pkg::OP_ORI || cmd.op == cpu_dp_pkg::OP_LDI) ?
			cmd.imm : rf[cmd.src];
		alu_o = alu8(cmd.op, opa, opb, cpu_flags); // RQ2
		pidx  = `PTR_BASE + {2'b00, cmd.ptr_sel, 1'b0}; // RQ14
		ptr   = {rf[pidx + 5'd1], rf[pidx]};
		sum16 = {rf[{cmd.dst[4:1], 1'b1}], rf[{cmd.dst[4:1], 1'b0}]} +
			{10'h000, cmd.imm[5:0]};
		w16        = sum16;
		wr8        = 1'b0;
		wr16       = 1'b0;
		wr_ptr     = 1'b0;
		next_ptr   = ptr;
		next_flags = alu_o.flags;
		next_sp    = stack_ptr;
		next_addr  = mem_addr;
		next_we    = 1'b0;
		next_re    = 1'b0;
		next_state = state;
		if (state == cpu_dp_pkg::ST_IRQ_RETURN)
		begin
			next_flags = cpu_flags;
			if (wait_cnt == 2'h0)
			begin
				next_sp = stack_ptr + SP_W'(2); // RQ19 RQ23
				next_flags[`FLAG_I] = 1'b1; // RQ6 RQ23
				next_state = cpu_dp_pkg::ST_RUN;
			end
		end else if (take_irq)
		begin
			next_flags = cpu_flags;
			next_flags[`FLAG_I] = 1'b0; // RQ3 RQ6
			next_sp = stack_ptr - SP_W'(2); // RQ18
		end else if (accept)
		begin
			unique case (cmd.op)
				cpu_dp_pkg::OP_ADD, cpu_dp_pkg::OP_ADC, cpu_dp_pkg::OP_SUB,
				cpu_dp_pkg::OP_SBC, cpu_dp_pkg::OP_AND, cpu_dp_pkg::OP_OR,
				cpu_dp_pkg::OP_EOR, cpu_dp_pkg::OP_SUBI, cpu_dp_pkg::OP_ANDI,
				cpu_dp_pkg::OP_ORI, cpu_dp_pkg::OP_MOV, cpu_dp_pkg::OP_LDI:
					wr8 = 1'b1; // RQ12
				cpu_dp_pkg::OP_MOVW:
				begin
					wr16 = 1'b1; // RQ12
					w16  = {rf[{cmd.src[4:1], 1'b1}], rf[{cmd.src[4:1], 1'b0}]};
				end
				cpu_dp_pkg::OP_ADIW:
				begin
					wr16 = 1'b1; // RQ12
					next_flags[`FLAG_V] =
						~rf[{cmd.dst[4:1], 1'b1}][7] & sum16[15]; // RQ10
					next_flags[`FLAG_N] = sum16[15];
					next_flags[`FLAG_Z] = sum16 == 16'h0000;
					next_flags[`FLAG_C] = ~sum16[15] & rf[{cmd.dst[4:1], 1'b1}][7];
					next_flags[`FLAG_S] = sum16[15] ^ next_flags[`FLAG_V]; // RQ9
				end
				cpu_dp_pkg::OP_BIT_STORE:
					next_flags[`FLAG_T] = opa[cmd.bit_sel]; // RQ7
				cpu_dp_pkg::OP_BIT_LOAD:
					wr8 = 1'b1; // RQ7
				cpu_dp_pkg::OP_SET_IE:
					next_flags[`FLAG_I] = 1'b1; // RQ6
				cpu_dp_pkg::OP_CLR_IE:
					next_flags[`FLAG_I] = 1'b0; // RQ6
				cpu_dp_pkg::OP_PUSH:
				begin
					next_addr = 16'(stack_ptr); // RQ16
					next_we   = 1'b1;
					next_sp   = stack_ptr - SP_W'(1); // RQ18
				end
				cpu_dp_pkg::OP_POP:
				begin
					next_sp   = stack_ptr + SP_W'(1); // RQ19
					next_addr = 16'(next_sp);
					next_re   = 1'b1;
				end
				cpu_dp_pkg::OP_CALL:
					next_sp = stack_ptr - SP_W'(2); // RQ18
				cpu_dp_pkg::OP_SUB_RETURN:
					next_sp = stack_ptr + SP_W'(2); // RQ19
				cpu_dp_pkg::OP_IRQ_RETURN:
					next_state = cpu_dp_pkg::ST_IRQ_RETURN; // RQ23
				cpu_dp_pkg::OP_PTR_INC:
				begin
					next_addr = ptr; // RQ15
					next_ptr  = ptr + 16'h0001;
					wr_ptr    = 1'b1;
					next_re   = 1'b1;
				end
				cpu_dp_pkg::OP_PTR_DEC:
				begin
					next_ptr  = ptr - 16'h0001; // RQ15
					next_addr = next_ptr;
					wr_ptr    = 1'b1;
					next_re   = 1'b1;
				end
				cpu_dp_pkg::OP_PTR_DISP:
				begin
					next_addr = ptr + {10'h000, cmd.disp}; // RQ15
					next_re   = 1'b1;
				end
				default:
					next_flags = cpu_flags;
			endcase
		end else
			next_flags = cpu_flags;
	end

	// bus writes land first so a concurrent instruction overrides them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 32; i++)
				rf[i] <= 8'h00;
		end else
		begin
			if (bus_wr && widx < `NUM_WREGS && s_axi_wstrb[0])
				rf[widx[4:0]] <= s_axi_wdata[7:0]; // RQ13
			if (wr8 && cmd.op == cpu_dp_pkg::OP_BIT_LOAD)
				rf[cmd.dst][cmd.bit_sel] <= cpu_flags[`FLAG_T]; // RQ7
			else if (wr8)
				rf[cmd.dst] <= alu_o.res; // RQ1 RQ22
			if (wr16)
			begin
				rf[{cmd.dst[4:1], 1'b0}] <= w16[7:0]; // RQ12
				rf[{cmd.dst[4:1], 1'b1}] <= w16[15:8];
			end
			if (wr_ptr)
			begin
				rf[pidx]        <= next_ptr[7:0]; // RQ14 RQ15
				rf[pidx + 5'd1] <= next_ptr[15:8];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cpu_flags <= `FLAGS_RST; // RQ4
		else if (bus_wr && widx == `IDX_FLAGS && s_axi_wstrb[0] &&
			!accept && !take_irq && state == cpu_dp_pkg::ST_RUN)
			cpu_flags <= s_axi_wdata[7:0]; // RQ4
		else
			cpu_flags <= next_flags;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stack_ptr <= SRAM_END[SP_W-1:0]; // RQ17
		else if (bus_wr && widx == `IDX_SP_LOW && s_axi_wstrb[0] &&
			next_sp == stack_ptr)
			stack_ptr <= SP_W'(s_axi_wdata[7:0]); // RQ20 RQ24
		else
			stack_ptr <= next_sp;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= cpu_dp_pkg::ST_RUN;
			wait_cnt  <= 2'h0;
			cmd_ready <= 1'b0;
			irq_taken <= 1'b0;
		end else
		begin
			state     <= next_state;
			cmd_ready <= next_state == cpu_dp_pkg::ST_RUN;
			irq_taken <= take_irq;
			if (state == cpu_dp_pkg::ST_RUN)
				wait_cnt <= `IRQ_RETURN_WAIT;
			else
				wait_cnt <= wait_cnt - 2'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alu_result <= 8'h00;
			mem_addr   <= 16'h0000;
			mem_wdata  <= 8'h00;
			mem_we     <= 1'b0;
			mem_re     <= 1'b0;
		end else
		begin
			if (wr8)
				alu_result <= alu_o.res;
			mem_addr <= next_addr;
			if (next_we)
				mem_wdata <= opa;
			mem_we <= next_we;
			mem_re <= next_re;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else
		begin
			s_axi_awready <= !s_axi_awready && !s_axi_bvalid &&
				s_axi_awvalid && s_axi_wvalid;
			s_axi_wready  <= !s_axi_awready && !s_axi_bvalid &&
				s_axi_awvalid && s_axi_wvalid;
			if (bus_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (bus_rd)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= is_mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
				if (ridx < `NUM_WREGS)
					s_axi_rdata <= {24'h000000, rf[ridx[4:0]]}; // RQ13
				else if (ridx == `IDX_SP_LOW)
					s_axi_rdata <= 32'(stack_ptr); // RQ20 RQ24
				else if (ridx == `IDX_FLAGS)
					s_axi_rdata <= {24'h000000, cpu_flags}; // RQ4
				else
					s_axi_rdata <= 32'h0000_0000; // RQ24
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	AST_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
		accept && cmd.op == cpu_dp_pkg::OP_ADD |=>
		alu_result == rf[$past(cmd.dst)])
		else $error("add result not written back in one cycle");
	AST_SIGN_XOR: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
		accept && cmd.op == cpu_dp_pkg::OP_SUB |=>
		cpu_flags[`FLAG_S] == (cpu_flags[`FLAG_N] ^ cpu_flags[`FLAG_V]))
		else $error("sign flag differs from N xor V");
	AST_ZERO_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
		accept && cmd.op == cpu_dp_pkg::OP_EOR |=>
		cpu_flags[`FLAG_Z] == (alu_result == 8'h00))
		else $error("zero flag wrong after logic op");
	AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
		irq_taken |-> $past(cpu_flags[`FLAG_I]) && !cpu_flags[`FLAG_I])
		else $error("interrupt taken with global enable clear");
	AST_IRQ_NO_SAVE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
		irq_taken |-> cpu_flags[6:0] == $past(cpu_flags[6:0]) &&
		stack_ptr == $past(stack_ptr) - SP_W'(2))
		else $error("interrupt entry altered flags or stack wrongly");
	AST_PUSH_DEC: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
		accept && cmd.op == cpu_dp_pkg::OP_PUSH |=>
		stack_ptr == $past(stack_ptr) - SP_W'(1) && mem_we)
		else $error("push did not lower stack pointer by one");
	AST_RETURN_INC: assert property (@(posedge aclk) disable iff (!aresetn) // RQ19
		accept && cmd.op == cpu_dp_pkg::OP_SUB_RETURN |=>
		stack_ptr == $past(stack_ptr) + SP_W'(2))
		else $error("return did not raise stack pointer by two");
	AST_BIT_STORE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
		accept && cmd.op == cpu_dp_pkg::OP_BIT_STORE |=>
		cpu_flags[`FLAG_T] == $past(opa[cmd.bit_sel]))
		else $error("bit store did not copy into T");
	AST_IRQ_RETURN_4: assert property (@(posedge aclk) disable iff (!aresetn) // RQ23
		accept && cmd.op == cpu_dp_pkg::OP_IRQ_RETURN |=>
		!cmd_ready [*3] ##1 (cmd_ready && cpu_flags[`FLAG_I]))
		else $error("interrupt return not four cycles");
	AST_CLR_IE: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
		accept && cmd.op == cpu_dp_pkg::OP_CLR_IE |=> !cpu_flags[`FLAG_I])
		else $error("clear enable left global enable set");

	COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn)
		irq_taken);
	COV_IRQ_RETURN: cover property (@(posedge aclk) disable iff (!aresetn)
		accept && cmd.op == cpu_dp_pkg::OP_IRQ_RETURN);
	COV_CARRY: cover property (@(posedge aclk) disable iff (!aresetn)
		accept && cmd.op == cpu_dp_pkg::OP_ADD ##1 cpu_flags[`FLAG_C]);
endmodule : cpu_datapath
`default_nettype wire

//--- hdl/cpu_dp_defs.svh
// Contract
// [RQ1] ALU finishes register-register or register-immediate operation in one cycle, all 32 registers.
// [RQ2] every ALU operation updates the flag register from its result.
// [RQ3] flags are not saved on interrupt entry nor restored on return.
// [RQ4] flag register is 8-bit RW at 0x3F, reset zero, bits I T H S V N Z C.
// [RQ5] no interrupt is taken while the global enable bit is clear.
// [RQ6] interrupt entry clears global enable; interrupt return and set-enable set it; clear-enable clears.
// [RQ7] bit store copies a register bit to T; bit load copies T into a register bit.
// [RQ8] bit 5 records low-nibble carry in arithmetic that defines it.
// [RQ9] bit 4 always equals negative XOR overflow.
// [RQ10] bit 3 is two's complement overflow; bit 2 is negative result.
// [RQ11] bit 1 is set for zero result; bit 0 records carry out.
// [RQ12] register file supports 8r/8w, 2x8r/8w, 2x8r/16w and 16r/16w schemes.
// [RQ13] each working register is reachable at data address equal to its index.
// [RQ14] registers 0x1A..0x1F form three 16-bit pointers, low byte at even index.
// [RQ15] pointers support fixed displacement, post increment and pre decrement.
// [RQ16] stack grows downward; stack pointer always points at the top.
// [RQ17] at reset the stack pointer holds the last data SRAM address.
// [RQ18] push lowers stack pointer by one; call or interrupt lowers it by two.
// [RQ19] pop raises stack pointer by one; both returns raise it by two.
// [RQ20] stack pointer sits in low and high 8-bit registers; high may be absent.
// [RQ21] logic runs on the undivided CPU clock.
// [RQ22] read operands, execute and write back in one cycle.
// [RQ23] interrupt return takes four cycles, pops two bytes, sets global enable.
// [RQ24] unused stack pointer bits read zero and ignore writes.
`ifndef CPU_DP_DEFS_SVH
`define CPU_DP_DEFS_SVH
`define IDX_SP_LOW  6'h3D
`define IDX_SP_HIGH 6'h3E
`define IDX_FLAGS   6'h3F
`define NUM_WREGS   6'h20
`define FLAGS_RST   8'h00
`define FLAG_I      7
`define FLAG_T      6
`define FLAG_H      5
`define FLAG_S      4
`define FLAG_V      3
`define FLAG_N      2
`define FLAG_Z      1
`define FLAG_C      0
`define PTR_BASE    5'h1A
`define SRAM_LAST   16'h009F
`define IRQ_RETURN_WAIT 2'h2
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

//--- hdl/cpu_dp_pkg.sv
package cpu_dp_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
		OP_SUBI, OP_ANDI, OP_ORI, OP_MOV, OP_LDI, OP_MOVW, OP_ADIW,
		OP_BIT_STORE, OP_BIT_LOAD, OP_SET_IE, OP_CLR_IE, OP_PUSH,
		OP_POP, OP_CALL, OP_SUB_RETURN, OP_IRQ_RETURN,
		OP_PTR_INC, OP_PTR_DEC, OP_PTR_DISP
	} op_t;

	typedef struct packed {
		op_t        op;
		logic [4:0] dst;
		logic [4:0] src;
		logic [7:0] imm;
		logic [2:0] bit_sel;
		logic [1:0] ptr_sel;
		logic [5:0] disp;
	} cmd_t;

	typedef struct packed {
		logic [7:0] res;
		logic [7:0] flags;
	} alu_out_t;

	typedef enum logic {ST_RUN, ST_IRQ_RETURN} state_t;
endpackage : cpu_dp_pkg

//--- verification/test_cpu_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_dp_defs.svh"

module test_cpu_datapath;
	logic                aclk = 1'b0;
	logic                aresetn = 1'b0;
	logic                cmd_valid = 1'b0;
	cpu_dp_pkg::cmd_t    cmd = '0;
	logic                cmd_ready, irq_taken, mem_we, mem_re;
	logic                irq_req = 1'b0;
	logic [7:0]          cpu_flags, stack_ptr, alu_result, mem_wdata;
	logic [15:0]         mem_addr;
	logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]         wdata = 32'h0, rdata;
	logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                arvalid = 1'b0, rready = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid;
	logic [1:0]          bresp, rresp, rsp;
	logic [31:0]         rd;
	int                  errors = 0;
	int                  samples_checked = 0;

	always #2 aclk = ~aclk;

	cpu_datapath u_cpu_datapath (
		.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .irq_req(irq_req), .irq_taken(irq_taken),
		.cpu_flags(cpu_flags), .stack_ptr(stack_ptr),
		.alu_result(alu_result), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// both channels offered together; each dropped on its own ready
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axi_read

	function automatic cpu_dp_pkg::cmd_t mk(input cpu_dp_pkg::op_t o,
		input logic [4:0] d, input logic [4:0] s, input logic [7:0] i,
		input logic [2:0] b);
		cpu_dp_pkg::cmd_t c;
		c = '0;
		c.op = o;
		c.dst = d;
		c.src = s;
		c.imm = i;
		c.bit_sel = b;
		return c;
	endfunction : mk

	// returns at the accepting edge; effects are sampled at the next one
	task automatic exec(input cpu_dp_pkg::cmd_t c);
		@(posedge aclk);
		cmd <= c;
		cmd_valid <= 1'b1;
		do @(posedge aclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
	endtask : exec

	task automatic alu_case(input cpu_dp_pkg::op_t o, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] r, input logic [7:0] f);
		axi_write(8'h04, {24'h0, a});
		axi_write(8'h08, {24'h0, b});
		exec(mk(o, 5'd1, 5'd2, b, 3'd0));
		@(posedge aclk);
		chk("alu_result", {8'h00, r}, {8'h00, alu_result});
		chk("cpu_flags", {8'h00, f}, {8'h00, cpu_flags});
		axi_read(8'h04);
		chk("r1", {8'h00, r}, rd[15:0]);
	endtask : alu_case

	task automatic test_reset;
		chk("flags_rst", 16'h0000, {8'h00, cpu_flags});
		chk("sp_rst", 16'h009F, {8'h00, stack_ptr});
	endtask : test_reset

	task automatic test_alu;
		alu_case(cpu_dp_pkg::OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h20);
		alu_case(cpu_dp_pkg::OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h2C);
		alu_case(cpu_dp_pkg::OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h23);
		alu_case(cpu_dp_pkg::OP_ADC, 8'h10, 8'h20, 8'h31, 8'h00);
		alu_case(cpu_dp_pkg::OP_ADD, 8'h80, 8'h80, 8'h00, 8'h1B);
		alu_case(cpu_dp_pkg::OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h35);
		alu_case(cpu_dp_pkg::OP_SBC, 8'h05, 8'h04, 8'h00, 8'h00);
		alu_case(cpu_dp_pkg::OP_SUBI, 8'h10, 8'h10, 8'h00, 8'h02);
		alu_case(cpu_dp_pkg::OP_EOR, 8'hF0, 8'h0F, 8'hFF, 8'h14);
		alu_case(cpu_dp_pkg::OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h02);
		alu_case(cpu_dp_pkg::OP_OR, 8'h80, 8'h01, 8'h81, 8'h14);
		alu_case(cpu_dp_pkg::OP_ORI, 8'h00, 8'h00, 8'h00, 8'h02);
		alu_case(cpu_dp_pkg::OP_LDI, 8'h55, 8'h3C, 8'h3C, 8'h02);
		alu_case(cpu_dp_pkg::OP_MOV, 8'h55, 8'h22, 8'h22, 8'h02);
		alu_case(cpu_dp_pkg::OP_ANDI, 8'h7F, 8'h0F, 8'h0F, 8'h00);
	endtask : test_alu

	task automatic test_bits;
		axi_write(8'h0C, 32'h40);
		axi_write(8'h10, 32'h00);
		exec(mk(cpu_dp_pkg::OP_BIT_STORE, 5'd3, 5'd3, 8'h00, 3'd6));
		@(posedge aclk);
		chk("t_bit", 16'h0001, {15'h0, cpu_flags[`FLAG_T]});
		exec(mk(cpu_dp_pkg::OP_BIT_LOAD, 5'd4, 5'd4, 8'h00, 3'd0));
		axi_read(8'h10);
		chk("r4", 16'h0001, rd[15:0]);
	endtask : test_bits

	task automatic test_irq;
		logic [6:0] keep;
		keep = cpu_flags[6:0];
		irq_req <= 1'b1;
		repeat (6)
		begin
			@(posedge aclk);
			chk("irq_masked", 16'h0000, {15'h0, irq_taken});
		end
		exec(mk(cpu_dp_pkg::OP_SET_IE, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("ie_set", 16'h0001, {15'h0, cpu_flags[`FLAG_I]});
		repeat (4)
			if (irq_taken !== 1'b1)
				@(posedge aclk);
		irq_req <= 1'b0;
		chk("irq_taken", 16'h0001, {15'h0, irq_taken});
		chk("ie_clr", 16'h0000, {15'h0, cpu_flags[`FLAG_I]});
		chk("sp_irq", 16'h009D, {8'h00, stack_ptr});
		chk("kept", {9'h0, keep}, {9'h0, cpu_flags[6:0]});
		exec(mk(cpu_dp_pkg::OP_IRQ_RETURN, 5'd0, 5'd0, 8'h00, 3'd0));
		repeat (3)
		begin
			@(posedge aclk);
			chk("return_busy", 16'h0000, {15'h0, cmd_ready});
		end
		@(posedge aclk);
		chk("return_ready", 16'h0001, {15'h0, cmd_ready});
		chk("sp_irq_return", 16'h009F, {8'h00, stack_ptr});
		chk("ie_irq_return", 16'h0001, {15'h0, cpu_flags[`FLAG_I]});
		chk("kept2", {9'h0, keep}, {9'h0, cpu_flags[6:0]});
		exec(mk(cpu_dp_pkg::OP_CLR_IE, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("ie_cli", 16'h0000, {15'h0, cpu_flags[`FLAG_I]});
	endtask : test_irq

	task automatic test_stack;
		axi_write(8'h00, 32'hA5);
		exec(mk(cpu_dp_pkg::OP_PUSH, 5'd0, 5'd1, 8'h00, 3'd0));
		@(posedge aclk);
		chk("sp_push", 16'h009E, {8'h00, stack_ptr});
		chk("push_data", 16'h00A5, {8'h00, mem_wdata});
		chk("push_addr", 16'h009F, mem_addr);
		chk("push_we", 16'h0001, {15'h0, mem_we});
		exec(mk(cpu_dp_pkg::OP_POP, 5'd5, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("sp_pop", 16'h009F, {8'h00, stack_ptr});
		chk("pop_re", 16'h0001, {15'h0, mem_re});
		exec(mk(cpu_dp_pkg::OP_CALL, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("sp_call", 16'h009D, {8'h00, stack_ptr});
		exec(mk(cpu_dp_pkg::OP_SUB_RETURN, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("sp_sub_return", 16'h009F, {8'h00, stack_ptr});
	endtask : test_stack

	task automatic test_ptr;
		cpu_dp_pkg::cmd_t c;
		axi_write(8'h68, 32'h30);
		axi_write(8'h6C, 32'h00);
		exec(mk(cpu_dp_pkg::OP_PTR_INC, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("inc_addr", 16'h0030, mem_addr);
		axi_read(8'h68);
		chk("ptr_inc", 16'h0031, rd[15:0]);
		exec(mk(cpu_dp_pkg::OP_PTR_DEC, 5'd0, 5'd0, 8'h00, 3'd0));
		@(posedge aclk);
		chk("dec_addr", 16'h0030, mem_addr);
		exec(mk(cpu_dp_pkg::OP_MOVW, 5'd6, 5'd26, 8'h00, 3'd0));
		axi_read(8'h18);
		chk("movw", 16'h0030, rd[15:0]);
		axi_write(8'h60, 32'hFF);
		axi_write(8'h64, 32'h7F);
		exec(mk(cpu_dp_pkg::OP_ADIW, 5'd24, 5'd0, 8'h01, 3'd0));
		@(posedge aclk);
		chk("adiw_flags", 16'h004C, {8'h00, cpu_flags});
		axi_read(8'h64);
		chk("adiw_high", 16'h0080, rd[15:0]);
		axi_write(8'h70, 32'h40);
		c = mk(cpu_dp_pkg::OP_PTR_DISP, 5'd0, 5'd0, 8'h00, 3'd0);
		c.ptr_sel = 2'd1;
		c.disp = 6'd5;
		exec(c);
		@(posedge aclk);
		chk("disp_addr", 16'h0045, mem_addr);
	endtask : test_ptr

	task automatic test_regs;
		axi_write(8'hFC, 32'h14);
		chk("wr_resp", 16'h0000, {14'h0, rsp});
		axi_read(8'hFC);
		chk("flags_rd", 16'h0014, rd[15:0]);
		chk("flags_out", 16'h0014, {8'h00, cpu_flags});
		axi_write(8'hF4, 32'h90);
		chk("sp_wr", 16'h0090, {8'h00, stack_ptr});
		axi_write(8'hF8, 32'h12);
		axi_read(8'hF8);
		chk("sp_high", 16'h0000, rd[15:0]);
		axi_read(8'h80);
		chk("rd_unmapped", {14'h0, `RESP_SLVERR}, {14'h0, rsp});
		axi_write(8'h84, 32'h55);
		chk("wr_unmapped", {14'h0, `RESP_SLVERR}, {14'h0, rsp});
	endtask : test_regs

	initial
	begin
		#100000;
		errors++;
		finish_test;
	end

	initial
	begin
		repeat (12) @(posedge aclk);
		test_reset;
		aresetn <= 1'b1;
		test_alu;
		test_bits;
		test_irq;
		test_stack;
		test_ptr;
		test_regs;
		repeat (4) @(posedge aclk);
		finish_test;
	end
endmodule : test_cpu_datapath
`default_nettype wire
